/* rtl/dsp_irq_pkg.sv */
// constants and types for the feature-enable and interrupt-mask register block
// Operation
// - feature bits 7..4 enable processing, reset 0
// - bits 3,2 enable tone generators, reset off
// - bit 1 selects battery or analog supply
// - bit 0 enables shutdown; threshold resets 0xBF
// - threshold compares upper eight measurement bits
// - clock mask bits 7,6; all reset 1
// - fault masks bits 5,4 reset 0
// - headset masks bits 3,2,1 reset 0
// - aux masks bits 7,6; register resets 0x30
// - latched bit 7 records clock error
// - latched bit 6 pll lock; 5..0 zero
// - headset latch bits 3,2,1 clear on read
package dsp_irq_pkg;
    // register offsets on the control port
    localparam logic [7:0] ADDR_FEATURE    = 8'h2D;
    localparam logic [7:0] ADDR_BROWNOUT   = 8'h2E;
    localparam logic [7:0] ADDR_MASK_CLOCK = 8'h2F;
    localparam logic [7:0] ADDR_MASK_FH    = 8'h32;
    localparam logic [7:0] ADDR_MASK_AUX   = 8'h33;
    localparam logic [7:0] ADDR_LATCH_CLK  = 8'h34;
    localparam logic [7:0] ADDR_LATCH_HS   = 8'h3A;
    // reset values
    localparam logic [7:0] RST_FEATURE     = 8'h00;
    localparam logic [7:0] RST_BROWNOUT    = 8'hBF;
    localparam logic [7:0] RST_MASK_CLOCK  = 8'hFF;
    localparam logic [7:0] RST_MASK_FH     = 8'h00;
    localparam logic [7:0] RST_MASK_AUX    = 8'h30;
    localparam logic [7:0] RST_LATCH       = 8'h00;
    // field positions
    localparam int BIT_CLK_ERR  = 7;
    localparam int BIT_PLL_LOCK = 6;
    localparam int BIT_HS_INS   = 3;
    localparam int BIT_HS_REM   = 2;
    localparam int BIT_HS_BTN   = 1;
    // implemented latch bits; the rest read zero
    localparam logic [7:0] LATCH_CLK_BITS  = 8'hC0;
    localparam logic [7:0] LATCH_HS_BITS   = 8'h0E;
    // supply measurement: 12 bits, threshold step 16 drops low 4 bits
    localparam int MEAS_W   = 12;
    localparam int MEAS_LSB = 4;

    // feature configuration, laid out in register bit order 7..0
    typedef struct packed {
        logic distortion_limiter_enable;
        logic battery_protection_enable;
        logic thermal_foldback_enable;
        logic range_compression_enable;
        logic tone_gen1_enable;
        logic tone_gen2_enable;
        logic supply_measure_source_select;   // 0 battery, 1 analog supply
        logic undervoltage_shutdown_enable;
    } feature_cfg_t;

    // one-cycle source events
    typedef struct packed {
        logic clock_error;
        logic pll_lock;
        logic headset_insert;
        logic headset_remove;
        logic headset_button;
    } irq_event_t;
endpackage

/* rtl/dsp_feature_irq.sv */
// feature enables, undervoltage shutdown, interrupt masks and latched interrupt status
`timescale 1ns/1ps
module dsp_feature_irq (
    // clock and reset
    input  wire logic                      core_clk_i,
    input  wire logic                      rstn_i,
    // register port
    input  wire logic [7:0]                reg_addr_i,
    input  wire logic                      reg_wr_i,
    input  wire logic [7:0]                reg_wdata_i,
    input  wire logic                      reg_rd_i,
    output logic [7:0]                     reg_rdata_o,
    output logic                           reg_rvalid_o,
    // supply measurements
    input  wire logic [11:0]               meas_battery_i,
    input  wire logic [11:0]               meas_analog_i,
    // interrupt sources
    input  wire dsp_irq_pkg::irq_event_t   event_i,
    // block outputs
    output dsp_irq_pkg::feature_cfg_t      feature_cfg_o,
    output logic [7:0]                     undervoltage_threshold_o,
    output logic [7:0]                     mask_fault_headset_o,
    output logic [7:0]                     mask_aux_input_o,
    output logic                           shutdown_o,
    output logic                           irq_o
);
    import dsp_irq_pkg::*;

    feature_cfg_t feature_r, feature_nxt;   // feature enables
    logic [7:0]   thresh_r,  thresh_nxt;    // undervoltage threshold
    logic [7:0]   mclk_r,    mclk_nxt;      // clock/pll masks
    logic [7:0]   mfh_r,     mfh_nxt;       // fault and headset masks
    logic [7:0]   maux_r,    maux_nxt;      // aux input masks
    logic [7:0]   lclk_r,    lclk_nxt;      // latched clock status
    logic [7:0]   lhs_r,     lhs_nxt;       // latched headset status
    logic         irq_r,     irq_nxt;
    logic [7:0]   rdata_r,   rdata_nxt;
    logic         rvalid_r,  rvalid_nxt;
    logic         shut_r,    shut_nxt;
    logic [7:0]   set_clk;                  // unmasked clock events
    logic [7:0]   set_hs;                   // unmasked headset events
    logic [MEAS_W-MEAS_LSB-1:0] meas_top;   // selected measurement, upper bits

    // configuration writes; reserved bits stored as written, host keeps them at reset value
    always_comb begin
        feature_nxt = feature_r;
        thresh_nxt  = thresh_r;
        mclk_nxt    = mclk_r;
        mfh_nxt     = mfh_r;
        maux_nxt    = maux_r;
        if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_FEATURE:    feature_nxt = feature_cfg_t'(reg_wdata_i);
                ADDR_BROWNOUT:   thresh_nxt  = reg_wdata_i;
                ADDR_MASK_CLOCK: mclk_nxt    = reg_wdata_i;
                ADDR_MASK_FH:    mfh_nxt     = reg_wdata_i;
                ADDR_MASK_AUX:   maux_nxt    = reg_wdata_i;
                default:         feature_nxt = feature_r;     // read-only or unmapped
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            feature_r <= feature_cfg_t'(RST_FEATURE);
            thresh_r  <= RST_BROWNOUT;
            mclk_r    <= RST_MASK_CLOCK;
            mfh_r     <= RST_MASK_FH;
            maux_r    <= RST_MASK_AUX;
        end else begin
            feature_r <= feature_nxt;
            thresh_r  <= thresh_nxt;
            mclk_r    <= mclk_nxt;
            mfh_r     <= mfh_nxt;
            maux_r    <= maux_nxt;
        end
    end

    // latch unmasked events; a read clears, but a same-cycle event wins
    always_comb begin
        set_clk = 8'h00;
        set_hs  = 8'h00;
        set_clk[BIT_CLK_ERR]  = event_i.clock_error    & ~mclk_r[BIT_CLK_ERR];
        set_clk[BIT_PLL_LOCK] = event_i.pll_lock       & ~mclk_r[BIT_PLL_LOCK];
        set_hs[BIT_HS_INS]    = event_i.headset_insert & ~mfh_r[BIT_HS_INS];
        set_hs[BIT_HS_REM]    = event_i.headset_remove & ~mfh_r[BIT_HS_REM];
        set_hs[BIT_HS_BTN]    = event_i.headset_button & ~mfh_r[BIT_HS_BTN];
        lclk_nxt = lclk_r;
        lhs_nxt  = lhs_r;
        if (reg_rd_i && reg_addr_i == ADDR_LATCH_CLK) begin
            lclk_nxt = 8'h00;
        end
        if (reg_rd_i && reg_addr_i == ADDR_LATCH_HS) begin
            lhs_nxt = 8'h00;
        end
        lclk_nxt = (lclk_nxt | set_clk) & LATCH_CLK_BITS;
        lhs_nxt  = (lhs_nxt  | set_hs)  & LATCH_HS_BITS;
        // registered irq tracks the new latch state, so no extra cycle of lag
        irq_nxt  = |(lclk_nxt & ~mclk_nxt) | |(lhs_nxt & ~mfh_nxt);
    end

    // latched status and interrupt line
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lclk_r <= RST_LATCH;
            lhs_r  <= RST_LATCH;
            irq_r  <= 1'b0;
        end else begin
            lclk_r <= lclk_nxt;
            lhs_r  <= lhs_nxt;
            irq_r  <= irq_nxt;
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rvalid_nxt = reg_rd_i;
        rdata_nxt  = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_FEATURE:    rdata_nxt = feature_r;
                ADDR_BROWNOUT:   rdata_nxt = thresh_r;
                ADDR_MASK_CLOCK: rdata_nxt = mclk_r;
                ADDR_MASK_FH:    rdata_nxt = mfh_r;
                ADDR_MASK_AUX:   rdata_nxt = maux_r;
                ADDR_LATCH_CLK:  rdata_nxt = lclk_r;
                ADDR_LATCH_HS:   rdata_nxt = lhs_r;
                default:         rdata_nxt = 8'h00;
            endcase
        end
    end

    // read data registers
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // undervoltage shutdown: selected supply top bits below threshold code
    always_comb begin
        meas_top = feature_r.supply_measure_source_select
                 ? meas_analog_i[MEAS_W-1:MEAS_LSB]
                 : meas_battery_i[MEAS_W-1:MEAS_LSB];
        shut_nxt = feature_r.undervoltage_shutdown_enable && (meas_top < thresh_r);
    end

    // shutdown flag
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shut_r <= 1'b0;
        end else begin
            shut_r <= shut_nxt;
        end
    end

    assign reg_rdata_o              = rdata_r;
    assign reg_rvalid_o             = rvalid_r;
    assign feature_cfg_o            = feature_r;
    assign undervoltage_threshold_o = thresh_r;
    assign mask_fault_headset_o     = mfh_r;
    assign mask_aux_input_o         = maux_r;
    assign shutdown_o               = shut_r;
    assign irq_o                    = irq_r;

    // checks
    property p_feature_wr;
        @(posedge core_clk_i) disable iff (!rstn_i)
        reg_wr_i && reg_addr_i == ADDR_FEATURE |=> feature_cfg_o == $past(reg_wdata_i);
    endproperty
    a_feature_wr: assert property (p_feature_wr) else $error("feature write lost");
    property p_tone_wr;
        @(posedge core_clk_i) disable iff (!rstn_i)
        reg_wr_i && reg_addr_i == ADDR_FEATURE
        |=> feature_cfg_o.tone_gen1_enable == $past(reg_wdata_i[3])
            && feature_cfg_o.tone_gen2_enable == $past(reg_wdata_i[2]);
    endproperty
    a_tone_wr: assert property (p_tone_wr) else $error("tone enable wrong");
    property p_shutdown;
        @(posedge core_clk_i) disable iff (!rstn_i)
        ##1 shutdown_o == $past(feature_cfg_o.undervoltage_shutdown_enable
            && ((feature_cfg_o.supply_measure_source_select ? meas_analog_i[11:4]
                 : meas_battery_i[11:4]) < undervoltage_threshold_o));
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown compare wrong");
    property p_clk_masked;
        @(posedge core_clk_i) disable iff (!rstn_i)
        event_i.clock_error && mclk_r[7] && !lclk_r[7] |=> !lclk_r[7];
    endproperty
    a_clk_masked: assert property (p_clk_masked) else $error("masked event latched");
    property p_fh_wr;
        @(posedge core_clk_i) disable iff (!rstn_i)
        reg_wr_i && reg_addr_i == ADDR_MASK_FH |=> mask_fault_headset_o == $past(reg_wdata_i);
    endproperty
    a_fh_wr: assert property (p_fh_wr) else $error("fault mask write lost");
    property p_aux_wr;
        @(posedge core_clk_i) disable iff (!rstn_i)
        reg_wr_i && reg_addr_i == ADDR_MASK_AUX |=> mask_aux_input_o == $past(reg_wdata_i);
    endproperty
    a_aux_wr: assert property (p_aux_wr) else $error("aux mask write lost");
    property p_clk_latch;
        @(posedge core_clk_i) disable iff (!rstn_i)
        event_i.clock_error && !mclk_r[7] |=> lclk_r[7] && (irq_o || mclk_r[7]);
    endproperty
    a_clk_latch: assert property (p_clk_latch) else $error("clock error not latched");
    property p_clk_zero;
        @(posedge core_clk_i) disable iff (!rstn_i)
        lclk_r[5:0] == 6'h00 && lhs_r[7:4] == 4'h0 && !lhs_r[0];
    endproperty
    a_clk_zero: assert property (p_clk_zero) else $error("reserved latch bit set");
    property p_hs_latch;
        @(posedge core_clk_i) disable iff (!rstn_i)
        event_i.headset_insert && !mfh_r[3] |=> lhs_r[3];
    endproperty
    a_hs_latch: assert property (p_hs_latch) else $error("insert not latched");
    property p_irq;
        @(posedge core_clk_i) disable iff (!rstn_i)
        irq_o == (|(lclk_r & ~mclk_r) || |(lhs_r & ~mfh_r));
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");
    property p_rd_clear;
        @(posedge core_clk_i) disable iff (!rstn_i)
        reg_rd_i && reg_addr_i == ADDR_LATCH_CLK && set_clk == 8'h00 |=> lclk_r == 8'h00;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("read did not clear");
    c_irq:      cover property (@(posedge core_clk_i) disable iff (!rstn_i) $rose(irq_o));
    c_shutdown: cover property (@(posedge core_clk_i) disable iff (!rstn_i) $rose(shutdown_o));
    c_race:     cover property (@(posedge core_clk_i) disable iff (!rstn_i)
                                reg_rd_i && reg_addr_i == ADDR_LATCH_HS && set_hs != 8'h00);
endmodule

/* bench/host_model.sv */
// host-side model driving the register port of the device
`timescale 1ns/1ps
module host_model (
    // clock
    input  wire logic       core_clk_i,
    // register port toward the device
    output logic [7:0]      reg_addr_o,
    output logic            reg_wr_o,
    output logic [7:0]      reg_wdata_o,
    output logic            reg_rd_o,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_rvalid_i
);
    // idle bus at time zero
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o    = 1'b0;
    end
    // reserved bits forced to their reset value before any write
    function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
        case (a)
            8'h2F:   return d | 8'h3F;
            8'h32:   return d & 8'h3E;
            8'h33:   return (d & 8'hC0) | 8'h30;
            default: return d;
        endcase
    endfunction
    // one-cycle write strobe, launched on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        reg_addr_o  = a;
        reg_wdata_o = legal(a, d);
        reg_wr_o    = 1'b1;
        @(negedge core_clk_i);
        reg_wr_o    = 1'b0;
        reg_wdata_o = ~reg_wdata_o;  // stale data is not left on the bus
    endtask
    // read strobe; the answer is only trusted while valid is high
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk_i);
        reg_addr_o = a;
        reg_rd_o   = 1'b1;
        @(negedge core_clk_i);
        reg_rd_o = 1'b0;
        d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hXX;
    endtask
endmodule

/* bench/tb_top.sv */
// self-checking bench for the feature and interrupt register block
`timescale 1ns/1ps
module tb_top;
    import dsp_irq_pkg::*;
    logic         core_clk_i = 1'b0;
    logic         rstn_i     = 1'b0;
    logic [7:0]   addr, wdata, rdata, thr, mfh, maux, d, v;
    logic         wr, rd, rvalid, shdn, irq;
    logic [11:0]  mb = 12'h000;
    logic [11:0]  ma = 12'h000;
    irq_event_t   ev = '0;
    feature_cfg_t feat;
    int           bad_count = 0;
    int           cmp_count = 0;
    int           seed      = 83;
    int           k;
    // writable registers and their shadow copies
    logic [7:0]   wa  [5] = '{ADDR_FEATURE, ADDR_BROWNOUT, ADDR_MASK_CLOCK, ADDR_MASK_FH, ADDR_MASK_AUX};
    logic [7:0]   shd [5] = '{8'h00, 8'hBF, 8'hFF, 8'h00, 8'h30};

    always #5 core_clk_i = ~core_clk_i;

    host_model host (.core_clk_i(core_clk_i), .reg_addr_o(addr), .reg_wr_o(wr),
        .reg_wdata_o(wdata), .reg_rd_o(rd), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

    dsp_feature_irq dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .meas_battery_i(mb), .meas_analog_i(ma), .event_i(ev),
        .feature_cfg_o(feat), .undervoltage_threshold_o(thr), .mask_fault_headset_o(mfh),
        .mask_aux_input_o(maux), .shutdown_o(shdn), .irq_o(irq));

    // compare one value, count it, report a mismatch at once
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // shutdown expected when enabled and the selected top byte is below threshold
    function automatic logic exp_shdn(logic [7:0] f, logic [7:0] t, logic [11:0] b, logic [11:0] a);
        return f[0] && ((f[1] ? a[11:4] : b[11:4]) < t);
    endfunction
    // one-cycle event pulse on the falling edge
    task automatic pulse(input logic [4:0] e);
        @(negedge core_clk_i);
        ev = e;
        @(negedge core_clk_i);
        ev = '0;
    endtask
    // verdict and end of run
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        bad_count++;
        wrap_up();
    end

    initial begin
        repeat (2) @(negedge core_clk_i);
        rstn_i = 1'b1;
        // reset values, clock latch included
        for (int i = 0; i < 5; i++) begin
            host.rd(wa[i], d);
            chk("reset", shd[i], d);
        end
        host.rd(ADDR_LATCH_CLK, d);
        chk("latch clk reset", 8'h00, d);
        // random writes with read-back and port checks
        for (int i = 0; i < 30; i++) begin
            k = ($random(seed) & 32'h7FFF) % 5;
            v = 8'($random(seed));
            host.wr(wa[k], v);
            shd[k] = host.legal(wa[k], v);
            host.rd(wa[k], d);
            chk("readback", shd[k], d);
            chk("feature", shd[0], feat);
            chk("threshold", shd[1], thr);
            chk("mask fh", shd[3], mfh);
            chk("mask aux", shd[4], maux);
        end
        // shutdown against random supply levels, equal top byte first
        for (int i = 0; i < 24; i++) begin
            shd[0] = 8'($random(seed));
            shd[1] = 8'($random(seed));
            host.wr(ADDR_FEATURE, shd[0]);
            host.wr(ADDR_BROWNOUT, shd[1]);
            @(negedge core_clk_i);
            mb = (i < 4) ? {shd[1], 4'hF} : 12'($random(seed));
            ma = (i < 4) ? {shd[1], 4'h0} : 12'($random(seed));
            repeat (2) @(negedge core_clk_i);
            chk("shutdown", 8'(exp_shdn(shd[0], shd[1], mb, ma)), 8'(shdn));
        end
        // masked clock events leave nothing behind
        host.wr(ADDR_MASK_CLOCK, 8'hFF);
        pulse(5'b11000);
        chk("irq masked", 8'h00, 8'(irq));
        host.rd(ADDR_LATCH_CLK, d);
        chk("latch masked", 8'h00, d);
        host.wr(ADDR_MASK_CLOCK, 8'h3F);
        for (int b = 7; b >= 6; b--) begin
            pulse(5'(1 << (b - 3)));
            chk("irq clk", 8'h01, 8'(irq));
            host.rd(ADDR_LATCH_CLK, d);
            chk("latch clk", 8'(1 << b), d);
            chk("irq cleared", 8'h00, 8'(irq));
        end
        // masking over a latched bit drops irq but keeps the latch
        pulse(5'b10000);
        host.wr(ADDR_MASK_CLOCK, 8'hFF);
        chk("irq remasked", 8'h00, 8'(irq));
        host.rd(ADDR_LATCH_CLK, d);
        chk("latch kept", 8'h80, d);
        // headset events one by one, then all masked
        host.wr(ADDR_MASK_FH, 8'h00);
        for (int b = 3; b >= 1; b--) begin
            pulse(5'(1 << (b - 1)));
            chk("irq hs", 8'h01, 8'(irq));
            host.rd(ADDR_LATCH_HS, d);
            chk("latch hs", 8'(1 << b), d);
        end
        host.wr(ADDR_MASK_FH, 8'h0E);
        pulse(5'b00111);
        host.rd(ADDR_LATCH_HS, d);
        chk("hs masked", 8'h00, d);
        // read and new event in the same cycle: the event wins
        host.wr(ADDR_MASK_FH, 8'h00);
        pulse(5'b00100);
        fork
            host.rd(ADDR_LATCH_HS, d);
            pulse(5'b00100);
        join
        chk("hs first", 8'h08, d);
        host.rd(ADDR_LATCH_HS, d);
        chk("hs kept", 8'h08, d);
        // latch is read-only, unmapped reads return zero
        host.wr(ADDR_LATCH_CLK, 8'hFF);
        host.rd(ADDR_LATCH_CLK, d);
        chk("latch ro", 8'h00, d);
        host.rd(8'h40, d);
        chk("unmapped", 8'h00, d);
        wrap_up();
    end
endmodule
